// ---- design/heater_regulator.v ----
// Heater regulator: serial register port, measurement sequencer and heater switch.
//
// Functional notes
// - Balance DAC current against element to measure.
// - Read-back code linear in ratio, zero at half.
// - Ratio 1.49 gives code all ones.
// - Equal resistances give mid-scale code.
// - Control bits 4:3 select reference current.
// - Pulse reference, then off for bits 7:5.
// - Hold target code, compare with measured code.
// - Switch on below target, off at/above.
// - Control bits 2:0 select heating mode.
// - Mode 0 disables everything including measurement.
// - Mode 1 regulates in closed loop.
// - Mode 2 measures, switch never on.
// - Mode 4 forced on, released during pulses.
// - Mode 5 always on, no measurement.
`timescale 1ns/1ns
`default_nettype none
`include "heater_defs.vh"

module heater_regulator #(
  parameter        CODE_WIDTH      = 8,
  parameter        SETTLE_CYCLES   = (`SETTLE_NS * `CLK_MHZ + 999) / 1000,
  parameter        OFF_BASE_CYCLES = (`OFF_BASE_NS * `CLK_MHZ) / 1000,
  parameter [7:0]  DEVICE_NUMBER   = 8'h5A
) (
  // Clock and reset
  input  wire                  ref_clk,
  input  wire                  resetn,
  // Three-wire serial register port
  input  wire                  sen_n,
  input  wire                  sclk,
  input  wire                  sdio_in,
  output reg                   sdio_out_q,
  output reg                   sdio_oe_n_q,
  // Analog measurement front end
  input  wire                  comp_hi,
  output wire [CODE_WIDTH-1:0] dac_code,
  output reg                   ref_on_q,
  output reg  [1:0]            ref_level_q,
  output reg                   circuit_en_q,
  // Heater switch
  output reg                   heat_on_q
);

  localparam ST_IDLE = 3'b001;
  localparam ST_MEAS = 3'b010;
  localparam ST_OFF  = 3'b100;
  localparam OFF_W   = 24;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  reg [1:0] sen_sync_q;
  reg [1:0] sclk_sync_q;
  reg [1:0] sdio_sync_q;
  reg [1:0] comp_sync_q;
  reg       sclk_prev_q;

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sen_sync_q  <= 2'b11;
      sclk_sync_q <= 2'b00;
      sdio_sync_q <= 2'b00;
      comp_sync_q <= 2'b00;
      sclk_prev_q <= 1'b0;
    end
    else
    begin
      sen_sync_q  <= {sen_sync_q[0], sen_n};
      sclk_sync_q <= {sclk_sync_q[0], sclk};
      sdio_sync_q <= {sdio_sync_q[0], sdio_in};
      comp_sync_q <= {comp_sync_q[0], comp_hi};
      sclk_prev_q <= sclk_sync_q[1];
    end
  end

  wire frame_on  = !sen_sync_q[1];
  wire sclk_rise = sclk_sync_q[1] && !sclk_prev_q;
  wire sclk_fall = !sclk_sync_q[1] && sclk_prev_q;
  wire comp_s    = comp_sync_q[1];

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  reg [7:0] device_select_q;
  reg [7:0] heater_control_q;
  reg [7:0] heater_set_point_q;
  reg [7:0] heater_read_back_q;
  reg       write_open_q;

  wire [2:0] mode    = heater_control_q[`CTL_MODE_MSB:`CTL_MODE_LSB];
  wire [1:0] level   = heater_control_q[`CTL_LEVEL_MSB:`CTL_LEVEL_LSB];
  wire [2:0] off_sel = heater_control_q[`CTL_OFF_MSB:`CTL_OFF_LSB];

  // ----------------------------------------------------------------------
  // Serial frame: one read/write bit, seven address bits, eight data bits.
  // ----------------------------------------------------------------------
  reg [4:0] bit_cnt_q;
  reg [7:0] hdr_q;
  reg [7:0] wdata_q;
  reg [7:0] rdata_q;

  wire       is_read  = hdr_q[7];
  wire [6:0] addr     = hdr_q[6:0];
  wire [7:0] hdr_next = {hdr_q[6:0], sdio_sync_q[1]};
  wire [7:0] wr_byte  = {wdata_q[6:0], sdio_sync_q[1]};

  reg [7:0] rd_mux;
  always @*
  begin
    rd_mux = 8'h00;
    if (hdr_next[6:0] == `OFS_DEVICE_SELECT)
      rd_mux = device_select_q;
    else if (hdr_next[6:0] == `OFS_HEATER_CONTROL)
      rd_mux = heater_control_q;
    else if (hdr_next[6:0] == `OFS_HEATER_SET_POINT)
      rd_mux = heater_set_point_q;
    else if (hdr_next[6:0] == `OFS_HEATER_READ_BACK)
      rd_mux = heater_read_back_q;
  end

  wire frame_end = frame_on && sclk_rise && (bit_cnt_q == `FRAME_BITS - 5'h01);
  wire wr_commit = frame_end && !is_read;

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bit_cnt_q   <= 5'h00;
      hdr_q       <= 8'h00;
      wdata_q     <= 8'h00;
      rdata_q     <= 8'h00;
      sdio_out_q  <= 1'b0;
      sdio_oe_n_q <= 1'b1;
    end
    else if (!frame_on)
    begin
      bit_cnt_q   <= 5'h00;
      sdio_oe_n_q <= 1'b1;
    end
    else
    begin
      if (sclk_rise && bit_cnt_q != `FRAME_BITS)
        bit_cnt_q <= bit_cnt_q + 5'h01;
      if (sclk_rise && bit_cnt_q < `FRAME_HDR_BITS)
        hdr_q <= hdr_next;
      if (sclk_rise && bit_cnt_q >= `FRAME_HDR_BITS)
        wdata_q <= wr_byte;
      // The device drives only after the header says read, so no bus fight.
      if (sclk_rise && bit_cnt_q == `FRAME_HDR_BITS - 5'h01 && hdr_next[7])
      begin
        rdata_q     <= {rd_mux[6:0], 1'b0};
        sdio_out_q  <= rd_mux[7];
        sdio_oe_n_q <= 1'b0;
      end
      else if (sclk_fall && is_read && bit_cnt_q > `FRAME_HDR_BITS
               && bit_cnt_q < `FRAME_BITS)
      begin
        sdio_out_q <= rdata_q[7];
        rdata_q    <= {rdata_q[6:0], 1'b0};
      end
      if (frame_end)
        sdio_oe_n_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Register writes; writes stay closed until the device select opens them.
  // ----------------------------------------------------------------------
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      device_select_q    <= `RST_DEVICE_SELECT;
      heater_control_q   <= `RST_HEATER_CONTROL;
      heater_set_point_q <= `RST_HEATER_SET_POINT;
      write_open_q       <= 1'b0;
    end
    else
    begin
      if (frame_end && is_read && addr == `OFS_DEVICE_SELECT)
        write_open_q <= 1'b0;
      if (wr_commit && addr == `OFS_DEVICE_SELECT)
      begin
        device_select_q <= wr_byte;
        write_open_q    <= (wr_byte == DEVICE_NUMBER);
      end
      else if (wr_commit && write_open_q && addr == `OFS_HEATER_CONTROL)
        heater_control_q <= wr_byte;
      else if (wr_commit && write_open_q && addr == `OFS_HEATER_SET_POINT)
        heater_set_point_q <= wr_byte;
    end
  end

  // ----------------------------------------------------------------------
  // Measurement sequencer
  // ----------------------------------------------------------------------
  // Reserved modes fall into the disabled branch, the safest reading.
  wire measuring = (mode == `MODE_REGULATE) || (mode == `MODE_MONITOR)
                   || (mode == `MODE_PULSED);

  reg  [2:0]            state_q;
  reg  [OFF_W-1:0]      off_cnt_q;
  reg                   heat_cmp_q;
  wire                  sar_start = measuring && state_q == ST_IDLE;
  wire                  sar_abort = !measuring;
  wire [CODE_WIDTH-1:0] sar_result;
  wire                  sar_busy;
  wire                  sar_done;

  sar_measure #(
    .WIDTH         (CODE_WIDTH),
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_sar (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .start      (sar_start),
    .abort      (sar_abort),
    .comp_hi    (comp_s),
    .dac_code_q (dac_code),
    .result_q   (sar_result),
    .busy_q     (sar_busy),
    .done_q     (sar_done)
  );

  // Longer off times save power but track temperature more slowly.
  wire [OFF_W-1:0] off_load = OFF_BASE_CYCLES[OFF_W-1:0] << off_sel;

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q            <= ST_IDLE;
      off_cnt_q          <= {OFF_W{1'b0}};
      heater_read_back_q <= `RST_HEATER_READ_BACK;
      heat_cmp_q         <= 1'b0;
    end
    else if (!measuring)
    begin
      state_q    <= ST_IDLE;
      heat_cmp_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          state_q <= ST_MEAS;
        ST_MEAS:
          if (sar_done)
          begin
            heater_read_back_q <= sar_result;
            heat_cmp_q         <= (sar_result < heater_set_point_q);
            off_cnt_q          <= off_load;
            state_q            <= ST_OFF;
          end
        ST_OFF:
          if (off_cnt_q <= {{(OFF_W-1){1'b0}}, 1'b1})
            state_q <= ST_IDLE;
          else
            off_cnt_q <= off_cnt_q - 1'b1;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Outputs to the analog front end and heater switch
  // ----------------------------------------------------------------------
  wire pulse_on = measuring && (sar_start || sar_busy);

  reg heat_d;
  always @*
  begin
    heat_d = 1'b0;
    case (mode)
      `MODE_REGULATE: heat_d = heat_cmp_q && !pulse_on;
      `MODE_MONITOR:  heat_d = 1'b0;
      `MODE_PULSED:   heat_d = !pulse_on;
      `MODE_FULL_ON:  heat_d = 1'b1;
      default:        heat_d = 1'b0;
    endcase
  end

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ref_on_q     <= 1'b0;
      ref_level_q  <= 2'b00;
      circuit_en_q <= 1'b0;
      heat_on_q    <= 1'b0;
    end
    else
    begin
      ref_on_q     <= pulse_on;
      ref_level_q  <= level;
      circuit_en_q <= measuring || (mode == `MODE_FULL_ON);
      heat_on_q    <= heat_d;
    end
  end

endmodule // heater_regulator

`default_nettype wire

// ---- shared/heater_defs.vh ----
// Register offsets, field positions, reset values and timing for the heater regulator.
`ifndef HEATER_DEFS_VH
`define HEATER_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets (7-bit serial address space)
// ----------------------------------------------------------------------
`define OFS_DEVICE_SELECT    7'h03
`define OFS_HEATER_CONTROL   7'h49
`define OFS_HEATER_SET_POINT 7'h4A
`define OFS_HEATER_READ_BACK 7'h4B

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_DEVICE_SELECT    8'h00
`define RST_HEATER_CONTROL   8'h00
`define RST_HEATER_SET_POINT 8'h00
`define RST_HEATER_READ_BACK 8'h00

// ----------------------------------------------------------------------
// Heater control fields
// ----------------------------------------------------------------------
`define CTL_MODE_MSB  2
`define CTL_MODE_LSB  0
`define CTL_LEVEL_MSB 4
`define CTL_LEVEL_LSB 3
`define CTL_OFF_MSB   7
`define CTL_OFF_LSB   5

// ----------------------------------------------------------------------
// Heating modes
// ----------------------------------------------------------------------
`define MODE_DISABLED 3'h0
`define MODE_REGULATE 3'h1
`define MODE_MONITOR  3'h2
`define MODE_PULSED   3'h4
`define MODE_FULL_ON  3'h5

// ----------------------------------------------------------------------
// Serial frame layout and timing
// ----------------------------------------------------------------------
`define FRAME_HDR_BITS  5'h08
`define FRAME_BITS      5'h10
`define CLK_MHZ         250
`define SETTLE_NS       64
`define OFF_BASE_NS     10000

`endif

// ---- design/sar_measure.v ----
// Successive-approximation search of the balancing DAC code.
`timescale 1ns/1ns
`default_nettype none
`include "heater_defs.vh"

module sar_measure #(
  parameter WIDTH         = 8,
  parameter SETTLE_CYCLES = (`SETTLE_NS * `CLK_MHZ + 999) / 1000
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             resetn,
  // Control
  input  wire             start,
  input  wire             abort,
  input  wire             comp_hi,
  // Results
  output reg  [WIDTH-1:0] dac_code_q,
  output reg  [WIDTH-1:0] result_q,
  output reg              busy_q,
  output reg              done_q
);

  localparam IW = $clog2(WIDTH);
  localparam SW = $clog2(SETTLE_CYCLES + 1);

  reg [IW-1:0] bit_q;
  reg [SW-1:0] settle_q;

  // ----------------------------------------------------------------------
  // Search: each trial bit settles, then the comparator decides it.
  // ----------------------------------------------------------------------
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dac_code_q <= {WIDTH{1'b0}};
      result_q   <= {WIDTH{1'b0}};
      busy_q     <= 1'b0;
      done_q     <= 1'b0;
      bit_q      <= {IW{1'b0}};
      settle_q   <= {SW{1'b0}};
    end
    else
    begin
      done_q <= 1'b0;
      if (abort)
      begin
        busy_q     <= 1'b0;
        dac_code_q <= {WIDTH{1'b0}};
      end
      else if (start && !busy_q)
      begin
        busy_q     <= 1'b1;
        bit_q      <= WIDTH[IW-1:0] - 1'b1;
        dac_code_q <= {1'b1, {(WIDTH-1){1'b0}}};
        settle_q   <= SETTLE_CYCLES[SW-1:0];
      end
      else if (busy_q)
      begin
        if (settle_q != {SW{1'b0}})
          settle_q <= settle_q - 1'b1;
        else
        begin
          // A low comparator means the reference side is too high: drop the bit.
          if (bit_q == {IW{1'b0}})
          begin
            busy_q   <= 1'b0;
            done_q   <= 1'b1;
            result_q <= comp_hi ? dac_code_q : (dac_code_q & ~{{(WIDTH-1){1'b0}}, 1'b1});
          end
          else
          begin
            dac_code_q <= (comp_hi ? dac_code_q : (dac_code_q & ~({{(WIDTH-1){1'b0}}, 1'b1} << bit_q)))
                          | ({{(WIDTH-1){1'b0}}, 1'b1} << (bit_q - 1'b1));
            bit_q      <= bit_q - 1'b1;
            settle_q   <= SETTLE_CYCLES[SW-1:0];
          end
        end
      end
    end
  end

endmodule // sar_measure

`default_nettype wire

// ---- bench/element_model.sv ----
// Heating element, reference resistor and comparator model.
`timescale 1ns/1ns
`default_nettype none
module element_model (
  // Drive from the device
  input  wire logic        ref_on_q,
  input  wire logic        circuit_en_q,
  input  wire logic [7:0]  dac_code,
  // Element to reference ratio in thousandths
  input  wire logic [15:0] ratio_milli,
  // Comparator
  output logic             comp_hi
);
  // --------------------------------------------------------------
  // Balance point
  // --------------------------------------------------------------
  int equiv;
  // Code zero at half ratio, 0x80 at equal, all ones at 1.49.
  assign equiv = (int'(ratio_milli) - 500) * 255 / 990;
  // With no current both pins sit at ground, so the comparator reads low.
  assign comp_hi = ref_on_q && circuit_en_q && (int'(dac_code) <= equiv);
endmodule // element_model
`default_nettype wire

// ---- bench/heater_props_props.sv ----
// Port-level checker for the heater regulator.
`timescale 1ns/1ns
`default_nettype none
module heater_props (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Serial port
  input  wire logic       sen_n,
  input  wire logic       sclk,
  input  wire logic       sdio_in,
  input  wire logic       sdio_out_q,
  input  wire logic       sdio_oe_n_q,
  // Measurement and switch
  input  wire logic       comp_hi,
  input  wire logic [7:0] dac_code,
  input  wire logic       ref_on_q,
  input  wire logic [1:0] ref_level_q,
  input  wire logic       circuit_en_q,
  input  wire logic       heat_on_q
);
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  oe_idle_a: assert property (
    sen_n [*4] |-> sdio_oe_n_q) else $error("output enable active outside frame");
  oe_start_a: assert property (
    $fell(sdio_oe_n_q) |-> !$past(sen_n, 3) && $past(sclk, 3))
    else $error("read drive began off a rise");
  out_hold_a: assert property (
    !sdio_oe_n_q && !$past(sdio_oe_n_q, 2) && sclk && $past(sclk) |-> $stable(sdio_out_q))
    else $error("read data moved while clock high");
  level_hold_a: assert property (
    sen_n [*8] |-> $stable(ref_level_q)) else $error("current level changed without write");
  circ_off_a: assert property (
    !circuit_en_q [*2] |-> !ref_on_q && !heat_on_q) else $error("activity while disabled");
  pulse_release_a: assert property (
    ref_on_q [*2] |-> !heat_on_q) else $error("switch on during pulse");
  off_time_a: assert property (
    $fell(ref_on_q) && circuit_en_q |-> !ref_on_q [*8]) else $error("off time too short");
  // A mode write needs a frame, so only stretches with the port quiet are judged.
  decision_hold_a: assert property (
    (circuit_en_q && !ref_on_q && sen_n) [*5] |-> $stable(heat_on_q))
    else $error("switch moved between pulses");
endmodule // heater_props
bind heater_regulator heater_props props (
  .ref_clk(ref_clk), .resetn(resetn), .sen_n(sen_n), .sclk(sclk), .sdio_in(sdio_in),
  .sdio_out_q(sdio_out_q), .sdio_oe_n_q(sdio_oe_n_q), .comp_hi(comp_hi),
  .dac_code(dac_code), .ref_on_q(ref_on_q), .ref_level_q(ref_level_q),
  .circuit_en_q(circuit_en_q), .heat_on_q(heat_on_q));
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the heater regulator.
`timescale 1ns/1ns
`default_nettype none
`include "heater_defs.vh"
module testbench;
  // --------------------------------------------------------------
  // Stimulus and checking
  // --------------------------------------------------------------
  localparam [7:0] OPEN_KEY = 8'h5A;
  logic        ref_clk, resetn, sen_n, sclk, host_d, comp_hi;
  logic        sdio_out_q, sdio_oe_n_q, ref_on_q, circuit_en_q, heat_on_q;
  logic [7:0]  dac_code;
  logic [1:0]  ref_level_q;
  logic [15:0] ratio_milli;
  int          mismatches = 0;
  int          n_checks = 0;
  int          cycles = 0;
  wire         sdio_in = sdio_oe_n_q ? host_d : sdio_out_q;

  heater_regulator #(.SETTLE_CYCLES(4), .OFF_BASE_CYCLES(8), .DEVICE_NUMBER(OPEN_KEY)) uut (
    .ref_clk(ref_clk), .resetn(resetn), .sen_n(sen_n), .sclk(sclk), .sdio_in(sdio_in),
    .sdio_out_q(sdio_out_q), .sdio_oe_n_q(sdio_oe_n_q), .comp_hi(comp_hi),
    .dac_code(dac_code), .ref_on_q(ref_on_q), .ref_level_q(ref_level_q),
    .circuit_en_q(circuit_en_q), .heat_on_q(heat_on_q));
  element_model model (.ref_on_q(ref_on_q), .circuit_en_q(circuit_en_q),
    .dac_code(dac_code), .ratio_milli(ratio_milli), .comp_hi(comp_hi));

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Each sclk phase lasts six cycles, safely above the three the sync needs.
  task automatic spi(input logic rw, input logic [6:0] a, input logic [7:0] wd,
                     output logic [7:0] rd);
    logic [15:0] f;
    f = {rw, a, wd};
    rd = 8'h00;
    @(posedge ref_clk) sen_n <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      host_d <= f[i];
      repeat (6) @(posedge ref_clk);
      if (i < 8) rd[i] = sdio_out_q;
      sclk <= 1'b1;
      repeat (6) @(posedge ref_clk);
      sclk <= 1'b0;
    end
    repeat (6) @(posedge ref_clk);
    sen_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e, input string what);
    logic [7:0] x;
    spi(1'b1, a, 8'h00, x);
    check(x, e, what);
  endtask

  // Opens write access, writes, then closes the session by reading select.
  task automatic cfg(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    spi(1'b0, `OFS_DEVICE_SELECT, OPEN_KEY, x);
    if (a == `OFS_HEATER_CONTROL) spi(1'b0, a, 8'h00, x);
    spi(1'b0, a, d, x);
    spi(1'b1, `OFS_DEVICE_SELECT, 8'h00, x);
  endtask

  task automatic wait_lvl(input logic v);
    for (int t = 0; t < 3000 && ref_on_q !== v; t++) @(posedge ref_clk);
    check({7'h00, ref_on_q}, {7'h00, v}, "pulse edge");
  endtask

  task automatic pulses(input int n);
    for (int k = 0; k < n; k++)
    begin
      wait_lvl(1'b1);
      wait_lvl(1'b0);
    end
  endtask

  task automatic t_reset;
    logic [7:0] x;
    check({4'h0, sdio_oe_n_q, ref_on_q, circuit_en_q, heat_on_q}, 8'h08, "reset pins");
    rd(`OFS_DEVICE_SELECT, 8'h00, "select reset");
    rd(`OFS_HEATER_CONTROL, 8'h00, "ctl reset");
    rd(`OFS_HEATER_SET_POINT, 8'h00, "sp reset");
    rd(`OFS_HEATER_READ_BACK, 8'h00, "rb reset");
    rd(7'h10, 8'h00, "unmapped");
    spi(1'b0, `OFS_HEATER_CONTROL, 8'h21, x);
    rd(`OFS_HEATER_CONTROL, 8'h00, "locked write");
    cfg(`OFS_HEATER_READ_BACK, 8'hAA);
    rd(`OFS_HEATER_READ_BACK, 8'h00, "read-only");
    spi(1'b0, `OFS_HEATER_CONTROL, 8'h21, x);
    rd(`OFS_HEATER_CONTROL, 8'h00, "closed write");
    rd(`OFS_DEVICE_SELECT, OPEN_KEY, "select");
  endtask

  // Set point boundary and the three documented ratio points.
  task automatic t_regulate;
    logic [15:0] r[4] = '{16'd1000, 16'd1000, 16'd500, 16'd1490};
    logic [7:0]  sp[4] = '{8'h80, 8'h81, 8'h80, 8'hFF};
    logic [7:0]  cd[4] = '{8'h80, 8'h80, 8'h00, 8'hFF};
    logic        ht[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    cfg(`OFS_HEATER_CONTROL, 8'h11);
    check({6'h00, ref_level_q}, 8'h02, "level");
    for (int i = 0; i < 4; i++)
    begin
      ratio_milli <= r[i];
      cfg(`OFS_HEATER_SET_POINT, sp[i]);
      rd(`OFS_HEATER_SET_POINT, sp[i], "sp");
      pulses(2);
      repeat (3) @(posedge ref_clk);
      check({7'h00, heat_on_q}, {7'h00, ht[i]}, "decision");
      rd(`OFS_HEATER_READ_BACK, cd[i], "code");
    end
  endtask

  // Observed as {enable seen, pulse seen, switch seen, switch always}.
  task automatic t_modes;
    logic [3:0] ex[8] = '{4'h0, 4'hC, 4'hC, 4'h0, 4'hE, 4'hB, 4'h0, 4'h0};
    logic [3:0] ob;
    ratio_milli <= 16'd1490;
    cfg(`OFS_HEATER_SET_POINT, 8'h80);
    for (int m = 0; m < 8; m++)
    begin
      cfg(`OFS_HEATER_CONTROL, {5'b00001, m[2:0]});
      repeat (20) @(posedge ref_clk);
      ob = 4'b0001;
      repeat (200)
      begin
        @(posedge ref_clk);
        ob = ob | {circuit_en_q, ref_on_q, heat_on_q, 1'b0};
        ob[0] = ob[0] & heat_on_q;
      end
      check({4'h0, ob}, {4'h0, ex[m]}, "mode");
    end
  endtask

  task automatic t_offtime;
    int n;
    int e;
    for (int f = 0; f < 8; f += 7)
    begin
      cfg(`OFS_HEATER_CONTROL, {f[2:0], 5'b11010});
      check({6'h00, ref_level_q}, 8'h03, "level");
      pulses(1);
      e = 8 << f;
      for (n = 0; n < 3000 && ref_on_q === 1'b0; n++) @(posedge ref_clk);
      check(8'(n >= e && n <= e + 2), 8'h01, "off time");
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      $display("[ERR] %0t run did not finish", $time);
      tally_and_finish();
    end
  end

  initial
  begin
    resetn = 1'b0;
    sen_n = 1'b1;
    sclk = 1'b0;
    host_d = 1'b0;
    ratio_milli = 16'd1000;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_regulate();
    t_modes();
    t_offtime();
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
